// *** rrex_core.sv ***
// Purpose: executes the two rotate-right instructions on an internal file memory
// Assumes: software issues instructions and reaches all state over Avalon-MM
// Notes: every access takes one wait cycle; accesses stall while an instruction runs
// Operation
// - opcode 001100 is rotate right with carry; then dest bit, bank bit, address.
// - with carry: bits move down, old carry into bit 7, bit 0 to carry.
// - dest bit 0 writes the accumulator; 1 writes back to the file register.
// - bank bit 0 picks access bank; 1 uses bank pointer for the bank.
// - bank bit 0, extended set on, address up to 95: indexed literal offset.
// - opcode 010000 is plain rotate right; then dest bit, bank bit, address.
// - plain: bits move down, bit 0 wraps to bit 7, carry kept, N Z updated.
module rrex_core #(
  parameter int BANK_W = 4
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  localparam int FA_W = BANK_W + 8;

  // file memory: all banks of general file storage
  logic [7:0] fmem [0:(2**FA_W)-1];

  rrex_pkg::rrex_phase_e phase_q, phase_d;
  logic rsp_q, rsp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] instr_q, instr_d;
  logic [7:0] accum_q, accum_d;
  logic c_q, c_d, z_q, z_d, n_q, n_d, ill_q, ill_d;
  logic [BANK_W-1:0] bank_q, bank_d;
  logic ext_q, ext_d;
  logic [FA_W-1:0] idx_q, idx_d;
  logic [FA_W-1:0] faddr_q, faddr_d;
  logic [FA_W-1:0] ea_q, ea_d;
  logic [7:0] opnd_q, opnd_d;
  logic [7:0] res_q, res_d;
  logic mem_we;
  logic [FA_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic bus_req, bus_go;
  logic [31:0] wr_word;

  // merge write data into a register word under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // effective file address from the address byte, bank bit and mode
  function automatic logic [FA_W-1:0] eff_addr(input logic [7:0] f, input logic a,
                                               input logic ext, input logic [BANK_W-1:0] bank,
                                               input logic [FA_W-1:0] idx);
    logic [FA_W-1:0] r;
    if (!a && ext && (f <= rrex_pkg::INDEX_LIMIT)) begin
      r = FA_W'(idx + {{BANK_W{1'b0}}, f});
    end else if (!a) begin
      // access bank: low half from bank 0, high half from the top bank
      r = (f < rrex_pkg::ACCESS_SPLIT) ? {{BANK_W{1'b0}}, f} : {{BANK_W{1'b1}}, f};
    end else begin
      r = {bank, f};
    end
    return r;
  endfunction

  // bus handshake: one wait cycle, longer while an instruction is in flight
  assign bus_req = AVS_READ | AVS_WRITE;
  assign bus_go = bus_req & rsp_q;
  assign AVS_WAITREQUEST = bus_req & ~rsp_q;
  assign AVS_READDATA = rdata_q;

  // next state for bus response, registers and the instruction phases
  always_comb begin
    phase_d = phase_q;
    rsp_d = 1'b0;
    rdata_d = rdata_q;
    instr_d = instr_q;
    accum_d = accum_q;
    c_d = c_q;
    z_d = z_q;
    n_d = n_q;
    ill_d = ill_q;
    bank_d = bank_q;
    ext_d = ext_q;
    idx_d = idx_q;
    faddr_d = faddr_q;
    ea_d = ea_q;
    opnd_d = opnd_q;
    res_d = res_q;
    mem_we = 1'b0;
    mem_wa = faddr_q;
    mem_wd = rrex_pkg::RST_BYTE;
    wr_word = rrex_pkg::RD_ZERO;
    // sample read data one cycle early so it comes from a flip-flop
    if (bus_req && !rsp_q && phase_q == rrex_pkg::RREX_IDLE) begin
      rsp_d = 1'b1;
      rdata_d = rrex_pkg::RD_ZERO;
      case (AVS_ADDRESS)
        rrex_pkg::OFS_INSTR: rdata_d[15:0] = instr_q;
        rrex_pkg::OFS_ACCUM: rdata_d[7:0] = accum_q;
        rrex_pkg::OFS_STATUS: begin
          rdata_d[rrex_pkg::ST_C_BIT] = c_q;
          rdata_d[rrex_pkg::ST_Z_BIT] = z_q;
          rdata_d[rrex_pkg::ST_N_BIT] = n_q;
          rdata_d[rrex_pkg::ST_ILL_BIT] = ill_q;
        end
        rrex_pkg::OFS_BANK: rdata_d[BANK_W-1:0] = bank_q;
        rrex_pkg::OFS_CFG: rdata_d[rrex_pkg::CFG_EXT_BIT] = ext_q;
        rrex_pkg::OFS_IDXBASE: rdata_d[FA_W-1:0] = idx_q;
        rrex_pkg::OFS_FADDR: rdata_d[FA_W-1:0] = faddr_q;
        rrex_pkg::OFS_FDATA: rdata_d[7:0] = fmem[faddr_q];
        default: rdata_d = rrex_pkg::RD_ZERO; // unmapped reads as zero
      endcase
    end
    // writes take effect at the edge where waitrequest is low
    if (bus_go && AVS_WRITE) begin
      case (AVS_ADDRESS)
        rrex_pkg::OFS_INSTR: begin
          wr_word = be_merge({16'h0000, instr_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
          instr_d = wr_word[15:0];
          phase_d = rrex_pkg::RREX_DECODE; // writing an instruction issues it
        end
        rrex_pkg::OFS_ACCUM: begin
          wr_word = be_merge({24'h00_0000, accum_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
          accum_d = wr_word[7:0];
        end
        rrex_pkg::OFS_STATUS: if (AVS_BYTEENABLE[0]) begin
          c_d = AVS_WRITEDATA[rrex_pkg::ST_C_BIT];
          z_d = AVS_WRITEDATA[rrex_pkg::ST_Z_BIT];
          n_d = AVS_WRITEDATA[rrex_pkg::ST_N_BIT];
        end
        rrex_pkg::OFS_BANK: if (AVS_BYTEENABLE[0]) begin
          bank_d = AVS_WRITEDATA[BANK_W-1:0];
        end
        rrex_pkg::OFS_CFG: if (AVS_BYTEENABLE[0]) begin
          ext_d = AVS_WRITEDATA[rrex_pkg::CFG_EXT_BIT];
        end
        rrex_pkg::OFS_IDXBASE: begin
          wr_word = be_merge({{(32-FA_W){1'b0}}, idx_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
          idx_d = wr_word[FA_W-1:0];
        end
        rrex_pkg::OFS_FADDR: begin
          wr_word = be_merge({{(32-FA_W){1'b0}}, faddr_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
          faddr_d = wr_word[FA_W-1:0];
        end
        rrex_pkg::OFS_FDATA: if (AVS_BYTEENABLE[0]) begin
          mem_we = 1'b1;
          mem_wa = faddr_q;
          mem_wd = AVS_WRITEDATA[7:0];
        end
        default: ; // unmapped writes are dropped
      endcase
    end
    // four phases of one instruction cycle
    case (phase_q)
      rrex_pkg::RREX_IDLE: ;
      rrex_pkg::RREX_DECODE: begin
        if (instr_q[15:10] == rrex_pkg::OPC_ROT_CARRY ||
            instr_q[15:10] == rrex_pkg::OPC_ROT_PLAIN) begin
          ill_d = 1'b0;
          ea_d = eff_addr(instr_q[7:0], instr_q[rrex_pkg::INS_BANKSEL_BIT], ext_q,
                          bank_q, idx_q);
          phase_d = rrex_pkg::RREX_READ;
        end else begin
          ill_d = 1'b1; // unknown opcode: flagged, nothing is changed
          phase_d = rrex_pkg::RREX_IDLE;
        end
      end
      rrex_pkg::RREX_READ: begin
        opnd_d = fmem[ea_q];
        phase_d = rrex_pkg::RREX_PROC;
      end
      rrex_pkg::RREX_PROC: begin
        if (instr_q[15:10] == rrex_pkg::OPC_ROT_CARRY) begin
          res_d = {c_q, opnd_q[7:1]};
          c_d = opnd_q[0];
        end else begin
          res_d = {opnd_q[0], opnd_q[7:1]}; // carry untouched
        end
        phase_d = rrex_pkg::RREX_WRITE;
      end
      rrex_pkg::RREX_WRITE: begin
        n_d = res_q[7];
        z_d = (res_q == rrex_pkg::RST_BYTE);
        if (instr_q[rrex_pkg::INS_DEST_BIT]) begin
          mem_we = 1'b1;
          mem_wa = ea_q;
          mem_wd = res_q;
        end else begin
          accum_d = res_q;
        end
        phase_d = rrex_pkg::RREX_IDLE;
      end
      default: phase_d = rrex_pkg::RREX_IDLE;
    endcase
  end

  // register stage for all control and data state
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      phase_q <= rrex_pkg::RREX_IDLE;
      rsp_q <= 1'b0;
      rdata_q <= rrex_pkg::RD_ZERO;
      instr_q <= rrex_pkg::RST_INSTR;
      accum_q <= rrex_pkg::RST_BYTE;
      c_q <= 1'b0;
      z_q <= 1'b0;
      n_q <= 1'b0;
      ill_q <= 1'b0;
      bank_q <= '0;
      ext_q <= 1'b0;
      idx_q <= '0;
      faddr_q <= '0;
      ea_q <= '0;
      opnd_q <= rrex_pkg::RST_BYTE;
      res_q <= rrex_pkg::RST_BYTE;
    end else begin
      phase_q <= phase_d;
      rsp_q <= rsp_d;
      rdata_q <= rdata_d;
      instr_q <= instr_d;
      accum_q <= accum_d;
      c_q <= c_d;
      z_q <= z_d;
      n_q <= n_d;
      ill_q <= ill_d;
      bank_q <= bank_d;
      ext_q <= ext_d;
      idx_q <= idx_d;
      faddr_q <= faddr_d;
      ea_q <= ea_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
    end
  end

  // file memory write port; no reset so it maps onto ram
  always_ff @(posedge CLK_SYS) begin
    if (mem_we) begin
      fmem[mem_wa] <= mem_wd;
    end
  end
endmodule

// *** rrex_pkg.sv ***
// Purpose: shared constants for the rotate-right execution unit
// Assumes: 32-bit Avalon-MM slave, byte addresses, one word per register
// Notes: status layout keeps carry, zero and negative in the low byte
package rrex_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_INSTR = 5'h00;
  localparam logic [4:0] OFS_ACCUM = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_BANK = 5'h0C;
  localparam logic [4:0] OFS_CFG = 5'h10;
  localparam logic [4:0] OFS_IDXBASE = 5'h14;
  localparam logic [4:0] OFS_FADDR = 5'h18;
  localparam logic [4:0] OFS_FDATA = 5'h1C;
  // status field positions
  localparam int ST_C_BIT = 0;
  localparam int ST_Z_BIT = 2;
  localparam int ST_N_BIT = 4;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_ILL_BIT = 9;
  // config field positions
  localparam int CFG_EXT_BIT = 0;
  // opcode patterns in instruction bits 15:10
  localparam logic [5:0] OPC_ROT_CARRY = 6'h0C;
  localparam logic [5:0] OPC_ROT_PLAIN = 6'h10;
  // instruction field positions
  localparam int INS_DEST_BIT = 9;
  localparam int INS_BANKSEL_BIT = 8;
  // access bank split and indexed-offset ceiling
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [7:0] INDEX_LIMIT = 8'h5F;
  // reset values
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // instruction phases
  typedef enum logic [2:0] {
    RREX_IDLE = 3'b000,
    RREX_DECODE = 3'b001,
    RREX_READ = 3'b010,
    RREX_PROC = 3'b011,
    RREX_WRITE = 3'b100
  } rrex_phase_e;
endpackage

// *** rrex_core_assertions.sv ***
// Purpose: port-level checks of the rotate-right unit's bus timing and register layout
// Assumes: one clock, asynchronous active-low reset, master releases after each answer
// Notes: rotate results are judged by the bench; here only port relations are watched
module rrex_core_assertions #(
  parameter int BANK_W = 4
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  // any request present
  logic req;
  assign req = AVS_READ | AVS_WRITE;
  // a valid instruction write accepted, then the following four phases
  // refused opcodes leave after decode, so they must not arm the stall check
  sequence instr_go;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == rrex_pkg::OFS_INSTR && AVS_BYTEENABLE[1] &&
      (AVS_WRITEDATA[15:10] == rrex_pkg::OPC_ROT_CARRY ||
       AVS_WRITEDATA[15:10] == rrex_pkg::OPC_ROT_PLAIN);
  endsequence
  sequence held_off;
    (!req || AVS_WAITREQUEST) [*4];
  endsequence
  AST_FIRST_WAIT: assert property (req && !$past(req) |-> AVS_WAITREQUEST)
    else $error("request answered without a wait cycle");
  AST_ANSWER: assert property ($rose(req) |-> ##[1:6] !AVS_WAITREQUEST)
    else $error("request not answered in time");
  AST_STALL: assert property (instr_go |=> held_off)
    else $error("bus answered while an instruction ran");
  AST_IDLE_NOWAIT: assert property (!req |-> !AVS_WAITREQUEST)
    else $error("waitrequest high with no request");
  AST_ONE_LOW: assert property (req && !AVS_WAITREQUEST |=> !req || AVS_WAITREQUEST)
    else $error("answer stood longer than one cycle");
  AST_UNMAPPED: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[1:0] != 2'b00
    |-> AVS_READDATA == rrex_pkg::RD_ZERO)
    else $error("unmapped read not zero");
  AST_ACC_WIDTH: assert property (AVS_READ && !AVS_WAITREQUEST &&
    AVS_ADDRESS == rrex_pkg::OFS_ACCUM |-> AVS_READDATA[31:8] == 24'h00_0000)
    else $error("accumulator upper bits set");
  AST_STATUS_LAYOUT: assert property (AVS_READ && !AVS_WAITREQUEST &&
    AVS_ADDRESS == rrex_pkg::OFS_STATUS |-> AVS_READDATA[31:10] == 22'h0 && !AVS_READDATA[8])
    else $error("status reserved bits set");
  AST_BANK_WIDTH: assert property (AVS_READ && !AVS_WAITREQUEST &&
    AVS_ADDRESS == rrex_pkg::OFS_BANK |-> AVS_READDATA[31:BANK_W] == '0)
    else $error("bank pointer upper bits set");
endmodule

// *** rrex_core_bench.sv ***
// Purpose: random and corner rotate instructions issued over the register bus
// Assumes: waitrequest answers every request; file memory seeded before each use
// Notes: expectations come from the bench's own address function and rotate expression
module rrex_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic [4:0] AVS_ADDRESS = 5'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  int error_cnt = 0;
  int compares = 0;
  int seed = 32'h2427_9886;
  logic [7:0] edge_f [4] = '{8'h5F, 8'h60, 8'h7F, 8'h80};
  logic [5:0] bad_op [3] = '{6'h0D, 6'h11, 6'h3F};
  // 40 MHz system clock
  always #12.5 CLK_SYS = ~CLK_SYS;
  rrex_core #(.BANK_W(4)) u_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST));
  // effective operand address, mirroring the documented bank selection
  function automatic logic [11:0] eff(logic a, logic [7:0] f, logic [3:0] bk, logic ext,
                                      logic [11:0] ib);
    if (a) return {bk, f};
    if (ext && f <= 8'h5F) return ib + {4'h0, f};
    return (f < 8'h80) ? {4'h0, f} : {4'hF, f};
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one bus transfer; request held until waitrequest is sampled low
  // waitrequest and read data are looked at mid-cycle, where they have settled,
  // so the edge that launches a new waitrequest value cannot be misread
  task automatic bus(logic w, logic [4:0] ad, logic [31:0] wd, output logic [31:0] rd);
    int n;
    logic wait_seen;
    n = 0;
    wait_seen = 1'b1;
    rd = 32'h0000_0000;
    @(posedge CLK_SYS);
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_ADDRESS <= ad;
    AVS_WRITEDATA <= wd;
    while (wait_seen !== 1'b0 && n < 50) begin
      @(negedge CLK_SYS);
      wait_seen = AVS_WAITREQUEST;
      rd = AVS_READDATA;
      n++;
      @(posedge CLK_SYS);
    end
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (wait_seen !== 1'b0) error_cnt++;
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence: reset, random rotates with boundary addresses, then refusals
  initial begin
    logic [31:0] rd;
    logic [7:0] f, v, acc0, res;
    logic op, d, a, ext, c;
    logic [3:0] bk;
    logic [11:0] ib;
    int r, r2;
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      r2 = $random(seed);
      {op, d, a, ext, c, bk, ib, f} = r[28:0];
      {v, acc0} = r2[15:0];
      if (i < 4) begin
        a = 1'b0;
        ext = 1'b1;
        f = edge_f[i];
      end
      bus(1'b1, rrex_pkg::OFS_BANK, {28'h0, bk}, rd);
      bus(1'b1, rrex_pkg::OFS_CFG, {31'h0, ext}, rd);
      bus(1'b1, rrex_pkg::OFS_IDXBASE, {20'h0, ib}, rd);
      bus(1'b1, rrex_pkg::OFS_FADDR, {20'h0, eff(a, f, bk, ext, ib)}, rd);
      bus(1'b1, rrex_pkg::OFS_FDATA, {24'h0, v}, rd);
      bus(1'b1, rrex_pkg::OFS_ACCUM, {24'h0, acc0}, rd);
      bus(1'b1, rrex_pkg::OFS_STATUS, {31'h0, c}, rd);
      bus(1'b1, rrex_pkg::OFS_INSTR,
        {16'h0, op ? rrex_pkg::OPC_ROT_CARRY : rrex_pkg::OPC_ROT_PLAIN, d, a, f}, rd);
      res = {op ? c : v[0], v[7:1]};
      bus(1'b0, rrex_pkg::OFS_ACCUM, 32'h0, rd);
      chk("accum", {24'h0, d ? acc0 : res}, rd);
      bus(1'b0, rrex_pkg::OFS_FDATA, 32'h0, rd);
      chk("file", {24'h0, d ? res : v}, rd);
      bus(1'b0, rrex_pkg::OFS_STATUS, 32'h0, rd);
      chk("status", {27'h0, res[7], 1'b0, res == 8'h00, 1'b0, op ? v[0] : c}, rd);
    end
    // near-miss opcodes and the all-ones opcode must be refused
    foreach (bad_op[k]) begin
      bus(1'b1, rrex_pkg::OFS_INSTR, {16'h0, bad_op[k], 10'h000}, rd);
      bus(1'b0, rrex_pkg::OFS_STATUS, 32'h0, rd);
      chk("refused", 32'h0000_0001, {31'h0, rd[rrex_pkg::ST_ILL_BIT]});
    end
    bus(1'b0, 5'h02, 32'h0, rd);
    chk("unmapped", 32'h0000_0000, rd);
    // byte enables off: the write must leave the accumulator untouched
    bus(1'b1, rrex_pkg::OFS_ACCUM, 32'h0000_003C, rd);
    AVS_BYTEENABLE <= 4'h0;
    bus(1'b1, rrex_pkg::OFS_ACCUM, 32'h0000_00A5, rd);
    AVS_BYTEENABLE <= 4'hF;
    bus(1'b0, rrex_pkg::OFS_ACCUM, 32'h0, rd);
    chk("masked", 32'h0000_003C, rd);
    bus(1'b0, rrex_pkg::OFS_BANK, 32'h0, rd);
    chk("bank", {28'h0, bk}, rd);
    print_verdict();
  end
  // watchdog well beyond the expected 1400 or so cycles
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    error_cnt++;
    print_verdict();
  end
endmodule
bind rrex_core rrex_core_assertions #(.BANK_W(BANK_W)) u_chk (.CLK_SYS(CLK_SYS),
  .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
